// ---- verilog/rgp_pkg.sv ----
package rgp_pkg;

    // Register offsets (byte addresses)
    localparam logic [7:0] RGP_A_PIN = 8'h00;
    localparam logic [7:0] RGP_A_TIMER = 8'h04;
    localparam logic [7:0] RGP_A_GPDATA = 8'h08;
    localparam logic [7:0] RGP_A_STAT = 8'h0c;
    localparam logic [7:0] RGP_A_SYSCTL = 8'h10;
    localparam logic [7:0] RGP_A_PMUCTL = 8'h14;
    localparam logic [7:0] RGP_A_CPURST = 8'h18;
    localparam logic [7:0] RGP_A_SCRATCH = 8'h1c;

    // Field positions
    localparam int RGP_F_PIN_POL = 4;
    localparam int RGP_F_SW_BIT = 0;
    localparam int RGP_F_WAKE_BIT = 0;
    localparam int RGP_F_CAUSE = 0;
    localparam int RGP_F_HELD = 1;
    localparam int RGP_F_SRC = 2;

    // Key that turns a write into a CPU restart request
    localparam logic [31:0] RGP_CPU_KEY = 32'h05fa0004;

    // Time factor: 7 bits, one unit is 4096 slow RC periods
    localparam int RGP_TFAC_W = 7;
    localparam logic [6:0] RGP_TFAC_MAX = 7'h7f;
    localparam logic [6:0] RGP_TFAC_RST = 7'h18;
    localparam int RGP_UNIT_LOG2 = 12;
    localparam int RGP_UNIT_TICKS = 4096;
    localparam int RGP_CNT_W = RGP_TFAC_W + RGP_UNIT_LOG2;
    localparam real RGP_LF_PERIOD_US = 31.25;
    localparam real RGP_UNIT_US = RGP_LF_PERIOD_US * RGP_UNIT_TICKS;

    // Reset line stretch in system clocks
    localparam logic [3:0] RGP_HOLD = 4'h8;
    localparam int RGP_GPIO_NUM = 12;

    typedef enum logic [2:0] {
        RGP_T_IDLE = 3'b001,
        RGP_T_RUN = 3'b010,
        RGP_T_HELD = 3'b100
    } rgp_tmr_e;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } rgp_bus_s;

    typedef struct packed {
        logic [3:0] pin_sel;
        logic pin_pol;
        logic [6:0] tfac;
        logic [31:0] gp_data;
        logic cause_por;
        logic sw_bit;
        logic wake_bit;
        logic [31:0] scratch;
        rgp_tmr_e tmr;
        logic [18:0] cnt;
        logic pad_q;
        logic src_q;
        logic trim_def;
        logic [3:0] por_cnt;
        logic [3:0] hw_cnt;
        logic [3:0] sw_cnt;
        logic boot;
        logic [31:0] rdata;
    } rgp_state_s;

    localparam rgp_state_s RGP_ST_RST = '{
        pin_sel: 4'h0, pin_pol: 1'b0, tfac: RGP_TFAC_RST, gp_data: 32'h0,
        cause_por: 1'b1, sw_bit: 1'b0, wake_bit: 1'b0, scratch: 32'h0,
        tmr: RGP_T_IDLE, cnt: 19'h0, pad_q: 1'b0, src_q: 1'b0,
        trim_def: 1'b0, por_cnt: RGP_HOLD, hw_cnt: 4'h0, sw_cnt: 4'h0,
        boot: 1'b0, rdata: 32'h0
    };

endpackage

// ---- verilog/rgp_reset_gen.sv ----
// Added by the designer: the placing of the registers and the address-and-strobe port.
`timescale 1ns/100ps
// Overview of operation
// - Three reset lines come out: power-on, hardware and software.
// - Power-on reset when an enabled source stays active for the programmed delay.
// - Software reset is CPU key-write request OR the software restart bit.
// - Power-on reset holds until core and both battery supplies are good.
// - With restart-on-wake set, waking from deep sleep gives a hardware reset.
// - Power-on and hardware reset both lead to a cold boot start.
// - Pin select, timer, general data and cause flag clear only on power-on.
// - Control registers clear on power-on or hardware reset, not software.
// - All other registers clear on any of the three resets.
// - The reset pad can always cause power-on reset.
// - Time factor is seven bits, largest value all ones.
// - Delay is factor times 4096 slow RC periods.
// - Slow RC oscillator forced on while any source is asserted.
// - Pad trigger uses default RC trim, GPIO trigger uses trimmed setting.
// - Short pad pulse gives hardware reset, long one gives power-on reset.
// - Reset pad is active high.
// - Monitored GPIO keeps working as an ordinary GPIO.
// - Pin select holds GPIO number; zero disables GPIO source.
// - Polarity bit: zero active low, one active high.
// - Source released before expiry clears the timer to zero.
// - Pad expires once until released; GPIO source may expire again.
module rgp_reset_gen #(
    parameter int GPIO_NUM = rgp_pkg::RGP_GPIO_NUM,
    parameter logic [3:0] HOLD = rgp_pkg::RGP_HOLD
) (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire rgp_pkg::rgp_bus_s i_bus,
    output logic [31:0] o_rdata,
    input wire logic i_reset_pad,
    input wire logic [GPIO_NUM-1:0] i_gpio,
    input wire logic i_lf_tick,
    input wire logic i_vdd_ok,
    input wire logic i_vbat_high_ok,
    input wire logic i_vbat_low_ok,
    input wire logic i_wake,
    output logic o_por,
    output logic o_hw_rst,
    output logic o_sw_rst,
    output logic o_cold_boot,
    output logic o_rc_force_on,
    output logic o_rc_default_trim
);

    rgp_pkg::rgp_state_s st_reg;
    rgp_pkg::rgp_state_s st_next;

    logic [15:0] gpio_ext;
    logic [15:0] gpio_ok;
    logic g_act;
    logic src;
    logic run_ok;
    logic expire;
    logic hw_evt;
    logic por_now;
    logic hw_now;
    logic sw_now;
    logic cpu_req;
    logic por_l;
    logic hw_l;
    logic sw_l;
    logic supply_ok;
    logic [18:0] target;

    // Pins at GPIO_NUM and above read as absent
    assign gpio_ext = 16'(i_gpio);
    assign gpio_ok = 16'({GPIO_NUM{1'b1}});

    always_comb begin
        st_next = st_reg;
        // Only observed, never driven: the pin stays a GPIO
        g_act = (st_reg.pin_sel != 4'h0) && gpio_ok[st_reg.pin_sel]
            && (gpio_ext[st_reg.pin_sel] == st_reg.pin_pol);
        src = i_reset_pad | g_act;
        target = {st_reg.tfac, 12'h000};
        run_ok = (st_reg.tmr == rgp_pkg::RGP_T_RUN) || g_act;
        expire = 1'b0;
        hw_evt = 1'b0;

        unique case (st_reg.tmr)
            rgp_pkg::RGP_T_IDLE: begin
                st_next.cnt = 19'h0;
                if (src) begin
                    st_next.tmr = rgp_pkg::RGP_T_RUN;
                end
            end
            rgp_pkg::RGP_T_RUN, rgp_pkg::RGP_T_HELD: begin
                if (!src) begin
                    st_next.tmr = rgp_pkg::RGP_T_IDLE;
                    st_next.cnt = 19'h0;
                end else if (!run_ok) begin
                    // Pad held after its expiry and no GPIO source
                    st_next.cnt = 19'h0;
                end else if (st_reg.cnt == target) begin
                    expire = 1'b1;
                    st_next.cnt = 19'h0;
                    if (i_reset_pad) begin
                        st_next.tmr = rgp_pkg::RGP_T_HELD;
                    end
                end else if (i_lf_tick) begin
                    st_next.cnt = 19'(st_reg.cnt + 19'h1);
                end
                // Overlapping sources keep the elapsed time
                if (src && st_reg.tmr == rgp_pkg::RGP_T_HELD && !i_reset_pad) begin
                    st_next.tmr = rgp_pkg::RGP_T_RUN;
                end
            end
        endcase

        // Pad let go before the long time: short press
        if (st_reg.pad_q && !i_reset_pad && st_reg.tmr == rgp_pkg::RGP_T_RUN
            && !expire) begin
            hw_evt = 1'b1;
        end

        supply_ok = i_vdd_ok & i_vbat_high_ok & i_vbat_low_ok;
        por_now = !supply_ok | expire;
        hw_now = hw_evt | (i_wake & st_reg.wake_bit);
        cpu_req = i_bus.wr && (i_bus.addr == rgp_pkg::RGP_A_CPURST)
            && (i_bus.wdata == rgp_pkg::RGP_CPU_KEY);
        sw_now = cpu_req | st_reg.sw_bit;

        // Each line is stretched to HOLD clocks
        st_next.por_cnt = por_now ? HOLD
            : (st_reg.por_cnt != 4'h0 ? 4'(st_reg.por_cnt - 4'h1) : 4'h0);
        st_next.hw_cnt = hw_now ? HOLD
            : (st_reg.hw_cnt != 4'h0 ? 4'(st_reg.hw_cnt - 4'h1) : 4'h0);
        st_next.sw_cnt = sw_now ? HOLD
            : (st_reg.sw_cnt != 4'h0 ? 4'(st_reg.sw_cnt - 4'h1) : 4'h0);

        por_l = st_reg.por_cnt != 4'h0;
        hw_l = por_l | (st_reg.hw_cnt != 4'h0);
        sw_l = hw_l | (st_reg.sw_cnt != 4'h0);
        // Boot starts as the cold reset lets go
        st_next.boot = hw_l && (st_next.por_cnt == 4'h0) && (st_next.hw_cnt == 4'h0);

        st_next.src_q = src;
        st_next.trim_def = i_reset_pad;
        st_next.pad_q = i_reset_pad;
        // Bit self-clears once taken, else the restart would repeat
        if (st_reg.sw_bit) begin
            st_next.sw_bit = 1'b0;
        end

        if (i_bus.wr) begin
            unique case (i_bus.addr)
                rgp_pkg::RGP_A_PIN: begin
                    st_next.pin_sel = i_bus.wdata[3:0];
                    st_next.pin_pol = i_bus.wdata[rgp_pkg::RGP_F_PIN_POL];
                end
                rgp_pkg::RGP_A_TIMER: st_next.tfac = i_bus.wdata[6:0];
                rgp_pkg::RGP_A_GPDATA: st_next.gp_data = i_bus.wdata;
                rgp_pkg::RGP_A_STAT: begin
                    if (i_bus.wdata[rgp_pkg::RGP_F_CAUSE]) begin
                        st_next.cause_por = 1'b0;
                    end
                end
                rgp_pkg::RGP_A_SYSCTL: begin
                    st_next.sw_bit = i_bus.wdata[rgp_pkg::RGP_F_SW_BIT];
                end
                rgp_pkg::RGP_A_PMUCTL: begin
                    st_next.wake_bit = i_bus.wdata[rgp_pkg::RGP_F_WAKE_BIT];
                end
                rgp_pkg::RGP_A_SCRATCH: st_next.scratch = i_bus.wdata;
                default: begin
                end
            endcase
        end

        st_next.rdata = 32'h0;
        if (i_bus.rd) begin
            unique case (i_bus.addr)
                rgp_pkg::RGP_A_PIN: st_next.rdata = 32'({st_reg.pin_pol, st_reg.pin_sel});
                rgp_pkg::RGP_A_TIMER: st_next.rdata = 32'(st_reg.tfac);
                rgp_pkg::RGP_A_GPDATA: st_next.rdata = st_reg.gp_data;
                rgp_pkg::RGP_A_STAT: st_next.rdata = 32'({st_reg.src_q,
                    st_reg.tmr == rgp_pkg::RGP_T_HELD, st_reg.cause_por});
                rgp_pkg::RGP_A_SYSCTL: st_next.rdata = 32'(st_reg.sw_bit);
                rgp_pkg::RGP_A_PMUCTL: st_next.rdata = 32'(st_reg.wake_bit);
                rgp_pkg::RGP_A_SCRATCH: st_next.rdata = st_reg.scratch;
                default: st_next.rdata = 32'h0;
            endcase
        end

        // Scoped clears; later ones override bus writes
        if (sw_l) begin
            st_next.scratch = 32'h0;
        end
        if (hw_l) begin
            st_next.sw_bit = 1'b0;
            st_next.wake_bit = 1'b0;
        end
        if (por_l) begin
            st_next.pin_sel = 4'h0;
            st_next.pin_pol = 1'b0;
            st_next.tfac = rgp_pkg::RGP_TFAC_RST;
            st_next.gp_data = 32'h0;
            st_next.cause_por = 1'b1; // Set wins over a clear
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            st_reg <= rgp_pkg::RGP_ST_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_rdata = st_reg.rdata;
    assign o_por = st_reg.por_cnt != 4'h0;
    assign o_hw_rst = o_por | (st_reg.hw_cnt != 4'h0);
    assign o_sw_rst = o_hw_rst | (st_reg.sw_cnt != 4'h0);
    assign o_cold_boot = st_reg.boot;
    assign o_rc_force_on = st_reg.src_q;
    assign o_rc_default_trim = st_reg.trim_def;

    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);

    sequence s_key_write;
        i_bus.wr && i_bus.addr == rgp_pkg::RGP_A_CPURST
            && i_bus.wdata == rgp_pkg::RGP_CPU_KEY;
    endsequence

    sequence s_short_press;
        st_reg.pad_q && !i_reset_pad && st_reg.tmr == rgp_pkg::RGP_T_RUN;
    endsequence

    a_supply_por: assert property (!supply_ok |=> o_por [*8])
        else $error("por not held for low supply");
    a_cpu_key: assert property (s_key_write |=> o_sw_rst ##1 o_sw_rst)
        else $error("key write gave no software reset");
    a_wake_hw: assert property (i_wake && st_reg.wake_bit && !o_hw_rst
        |=> o_hw_rst && !o_por)
        else $error("wake did not give hardware reset");
    a_timer_clear: assert property (!src |=> st_reg.cnt == 19'h0)
        else $error("timer not cleared on release");
    a_short_press: assert property (s_short_press and (st_reg.cnt != target)
        |=> o_hw_rst)
        else $error("short press gave no hardware reset");
    a_expire_por: assert property (expire |=> o_por ##1 o_por)
        else $error("expiry gave no power-on reset");
    a_pad_once: assert property (st_reg.tmr == rgp_pkg::RGP_T_HELD && i_reset_pad
        && !g_act |-> !expire)
        else $error("pad expired twice");
    a_sel_zero: assert property (st_reg.pin_sel == 4'h0 && !i_reset_pad
        |=> st_reg.tmr == rgp_pkg::RGP_T_IDLE)
        else $error("disabled source started timer");
    a_por_scope: assert property (o_por |=> st_reg.tfac == rgp_pkg::RGP_TFAC_RST
        && st_reg.pin_sel == 4'h0)
        else $error("por did not clear its registers");
    a_sw_scope: assert property (o_sw_rst && !o_hw_rst && !(i_bus.wr
        && i_bus.addr == rgp_pkg::RGP_A_TIMER) |=> $stable(st_reg.tfac)
        && st_reg.scratch == 32'h0)
        else $error("software reset scope wrong");
    a_hw_scope: assert property (o_hw_rst |=> !st_reg.wake_bit)
        else $error("hardware reset kept control bit");
    a_rc_on: assert property (src |=> o_rc_force_on)
        else $error("slow oscillator not forced on");
    a_pad_trim: assert property (i_reset_pad |=> o_rc_default_trim)
        else $error("pad trigger not on default trim");
    a_read_one: assert property (i_bus.rd && i_bus.addr == rgp_pkg::RGP_A_TIMER
        && !o_por |=> o_rdata == 32'($past(st_reg.tfac)))
        else $error("timer read back wrong");

    // Line nesting: a wider reset always implies the narrower ones
    a_por_in_hw: assert property (o_por
        |-> o_hw_rst)
        else $error("por without hardware reset");
    a_hw_in_sw: assert property (o_hw_rst
        |-> o_sw_rst)
        else $error("hardware reset without software reset");
    a_hw_stretch: assert property (hw_now
        |=> o_hw_rst [*8])
        else $error("hardware reset not stretched");
    a_sw_stretch: assert property (sw_now
        |=> o_sw_rst [*8])
        else $error("software reset not stretched");
    a_sw_bit_req: assert property (st_reg.sw_bit
        |=> o_sw_rst)
        else $error("restart bit gave no software reset");
    a_sw_bit_clear: assert property (st_reg.sw_bit
        && !(i_bus.wr && i_bus.addr == rgp_pkg::RGP_A_SYSCTL)
        |=> !st_reg.sw_bit)
        else $error("restart bit did not self clear");
    a_supply_boot: assert property (!supply_ok
        |=> !o_cold_boot)
        else $error("boot started with low supply");

    // Boot marks the end of a cold reset only
    a_boot_pulse: assert property (o_cold_boot
        |=> !o_cold_boot)
        else $error("boot pulse too long");
    a_boot_start: assert property ($fell(o_hw_rst)
        |-> o_cold_boot)
        else $error("no boot after cold reset");
    a_boot_cause: assert property (o_cold_boot
        |-> $past(o_hw_rst))
        else $error("boot without cold reset");

    // Scope of each reset line
    a_por_cause: assert property (o_por
        |=> st_reg.cause_por)
        else $error("cause flag not set by por");
    a_hw_keeps_gp: assert property (o_hw_rst && !o_por
        && !(i_bus.wr && i_bus.addr == rgp_pkg::RGP_A_GPDATA)
        |=> $stable(st_reg.gp_data))
        else $error("hardware reset touched general data");
    a_hw_sw_bit: assert property (o_hw_rst
        |=> !st_reg.sw_bit)
        else $error("hardware reset kept restart bit");
    a_sw_keeps_wake: assert property (o_sw_rst && !o_hw_rst
        && !(i_bus.wr && i_bus.addr == rgp_pkg::RGP_A_PMUCTL)
        |=> $stable(st_reg.wake_bit))
        else $error("software reset touched wake bit");

    // Sources and timer
    a_pad_src: assert property (i_reset_pad
        |-> src)
        else $error("pad not seen as source");
    a_tfac_write: assert property (i_bus.wr && i_bus.addr == rgp_pkg::RGP_A_TIMER && !o_por
        |=> st_reg.tfac == $past(i_bus.wdata[6:0]))
        else $error("time factor write lost");
    a_cnt_hold: assert property (st_reg.tmr == rgp_pkg::RGP_T_RUN && src
        && st_reg.cnt != target && !i_lf_tick
        |=> $stable(st_reg.cnt))
        else $error("timer moved without tick");
    a_cnt_step: assert property (st_reg.tmr == rgp_pkg::RGP_T_RUN && src
        && st_reg.cnt != target && i_lf_tick
        |=> st_reg.cnt == 19'($past(st_reg.cnt) + 19'h1))
        else $error("timer did not advance on tick");
    a_rc_off: assert property (!src
        |=> !o_rc_force_on)
        else $error("slow oscillator forced without source");
    a_gpio_trim: assert property (!i_reset_pad
        |=> !o_rc_default_trim)
        else $error("gpio trigger not on trimmed setting");
    a_long_no_hw: assert property (expire
        |-> !hw_evt)
        else $error("long press gave hardware reset");
    a_idle_start: assert property (st_reg.tmr == rgp_pkg::RGP_T_IDLE && src
        |=> st_reg.tmr == rgp_pkg::RGP_T_RUN)
        else $error("source did not start timer");
    a_gpio_off: assert property (st_reg.pin_sel == 4'h0
        |-> !g_act)
        else $error("zero select left gpio source on");
    a_pol_high: assert property (st_reg.pin_sel != 4'h0 && int'(st_reg.pin_sel) < GPIO_NUM
        && st_reg.pin_pol && gpio_ext[st_reg.pin_sel]
        |-> g_act)
        else $error("active high gpio not seen");
    a_pol_low: assert property (st_reg.pin_sel != 4'h0 && int'(st_reg.pin_sel) < GPIO_NUM
        && !st_reg.pin_pol && !gpio_ext[st_reg.pin_sel]
        |-> g_act)
        else $error("active low gpio not seen");
    a_pad_held: assert property (expire && i_reset_pad
        |=> st_reg.tmr == rgp_pkg::RGP_T_HELD)
        else $error("pad expiry not held");
    a_gpio_again: assert property (expire && !i_reset_pad
        |=> st_reg.tmr == rgp_pkg::RGP_T_RUN)
        else $error("gpio source cannot expire again");
    a_no_early: assert property (st_reg.cnt != target
        |-> !expire)
        else $error("timer expired early");

    // Read port answers only the cycle after a read
    a_rd_idle: assert property (!i_bus.rd
        |=> o_rdata == 32'h0)
        else $error("read data outside read cycle");
    a_rd_unmapped: assert property (i_bus.rd && i_bus.addr == 8'h20
        |=> o_rdata == 32'h0)
        else $error("unmapped read not zero");

endmodule // rgp_reset_gen

// ---- tb/rgp_src_model.sv ----
`timescale 1ns/100ps
module rgp_src_model #(
    parameter int GPIO_NUM = 12
) (
    input wire logic i_clk,
    output logic o_pad,
    output logic [GPIO_NUM-1:0] o_gpio
);
    // Pull-down on the pad: a released pad reads low
    initial begin
        o_pad = 1'b0;
        o_gpio = '1;
    end
    task automatic pad(input logic lvl);
        @(posedge i_clk);
        o_pad <= lvl;
    endtask
    task automatic pin(input int idx, input logic lvl);
        @(posedge i_clk);
        o_gpio[idx] <= lvl;
    endtask
endmodule // rgp_src_model

// ---- tb/testbench.sv ----
`timescale 1ns/100ps
module testbench;
    logic i_sys_clk;
    logic i_rst;
    rgp_pkg::rgp_bus_s bus;
    logic [31:0] o_rdata;
    logic pad;
    logic [11:0] gpio;
    logic [2:0] supply;
    logic wake;
    logic lf_tick;
    logic o_por, o_hw_rst, o_sw_rst, o_cold_boot, o_rc_force_on, o_rc_default_trim;
    int err_count = 0;
    int compares = 0;
    int cycles = 0;
    rgp_src_model src (.i_clk(i_sys_clk), .o_pad(pad), .o_gpio(gpio));
    // Slow tick every cycle: one time unit is 4096 system clocks
    rgp_reset_gen DUT (
        .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_bus(bus), .o_rdata(o_rdata),
        .i_reset_pad(pad), .i_gpio(gpio), .i_lf_tick(lf_tick), .i_vdd_ok(supply[0]),
        .i_vbat_high_ok(supply[1]), .i_vbat_low_ok(supply[2]), .i_wake(wake),
        .o_por(o_por), .o_hw_rst(o_hw_rst), .o_sw_rst(o_sw_rst), .o_cold_boot(o_cold_boot),
        .o_rc_force_on(o_rc_force_on), .o_rc_default_trim(o_rc_default_trim));
    initial begin
        i_sys_clk = 1'b0;
        forever #5 i_sys_clk = ~i_sys_clk;
    end
    task automatic print_verdict();
        $display("err_count=%0d compares=%0d", err_count, compares);
        if (err_count == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    always @(posedge i_sys_clk) begin
        cycles++;
        if (cycles == 60000) begin
            err_count++;
            print_verdict();
        end
    end
    task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp_flags(input logic [3:0] got, input logic [3:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: flags %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge i_sys_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_sys_clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge i_sys_clk);
        bus.wr <= 1'b0;
    endtask
    task automatic chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        @(posedge i_sys_clk);
        bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge i_sys_clk);
        bus.rd <= 1'b0;
        #1 cmp_reg(o_rdata & m, e);
    endtask
    // Flags seen high over a window: {por, hw, sw, boot}
    task automatic watch(input int n, input logic [3:0] e);
        logic [3:0] f;
        f = 4'h0;
        repeat (n) begin
            @(posedge i_sys_clk);
            #1 f = f | {o_por, o_hw_rst, o_sw_rst, o_cold_boot};
        end
        cmp_flags(f, e);
    endtask
    // Registers are cleared while lines stand, so wait them out first
    task automatic settle();
        for (int i = 0; i < 200 && o_sw_rst !== 1'b0; i++) @(posedge i_sys_clk);
        cyc(2);
    endtask
    task automatic pulse_wake();
        @(posedge i_sys_clk);
        wake <= 1'b1;
        @(posedge i_sys_clk);
        wake <= 1'b0;
    endtask
    initial begin
        i_rst = 1'b1;
        bus = '0;
        supply = 3'b111;
        wake = 1'b0;
        lf_tick = 1'b1;
        cyc(6);
        i_rst <= 1'b0;
        watch(14, 4'b1111);
        settle();
        chk(rgp_pkg::RGP_A_TIMER, 32'hffffffff, 32'h18);
        chk(rgp_pkg::RGP_A_STAT, 32'h1, 32'h1);
        wr(rgp_pkg::RGP_A_STAT, 32'h1);
        chk(rgp_pkg::RGP_A_STAT, 32'h1, 32'h0);
        wr(rgp_pkg::RGP_A_TIMER, 32'hff);
        chk(rgp_pkg::RGP_A_TIMER, 32'hffffffff, 32'h7f);
        chk(8'h20, 32'hffffffff, 32'h0);
        wr(rgp_pkg::RGP_A_GPDATA, 32'ha5a5a5a5);
        wr(rgp_pkg::RGP_A_SCRATCH, 32'h1234);
        wr(rgp_pkg::RGP_A_PMUCTL, 32'h1);
        wr(rgp_pkg::RGP_A_PIN, 32'h5);
        wr(rgp_pkg::RGP_A_CPURST, 32'h05fa0005);
        watch(12, 4'b0000);
        wr(rgp_pkg::RGP_A_CPURST, rgp_pkg::RGP_CPU_KEY);
        watch(12, 4'b0010);
        settle();
        chk(rgp_pkg::RGP_A_GPDATA, 32'hffffffff, 32'ha5a5a5a5);
        chk(rgp_pkg::RGP_A_SCRATCH, 32'hffffffff, 32'h0);
        chk(rgp_pkg::RGP_A_PMUCTL, 32'h1, 32'h1);
        chk(rgp_pkg::RGP_A_PIN, 32'h1f, 32'h5);
        wr(rgp_pkg::RGP_A_SYSCTL, 32'h1);
        watch(12, 4'b0010);
        settle();
        wr(rgp_pkg::RGP_A_TIMER, 32'h1);
        src.pad(1'b1);
        cyc(50);
        #1 cmp_flags({o_rc_force_on, o_rc_default_trim, 2'b00}, 4'b1100);
        src.pad(1'b0);
        watch(20, 4'b0111);
        settle();
        chk(rgp_pkg::RGP_A_PMUCTL, 32'h1, 32'h0);
        chk(rgp_pkg::RGP_A_GPDATA, 32'hffffffff, 32'ha5a5a5a5);
        src.pad(1'b1);
        watch(4080, 4'b0000);
        watch(40, 4'b1111);
        settle();
        chk(rgp_pkg::RGP_A_TIMER, 32'hffffffff, 32'h18);
        chk(rgp_pkg::RGP_A_GPDATA, 32'hffffffff, 32'h0);
        chk(rgp_pkg::RGP_A_STAT, 32'h1, 32'h1);
        wr(rgp_pkg::RGP_A_TIMER, 32'h1);
        watch(6000, 4'b0000);
        src.pad(1'b0);
        settle();
        wr(rgp_pkg::RGP_A_PMUCTL, 32'h1);
        pulse_wake();
        watch(12, 4'b0111);
        settle();
        pulse_wake();
        watch(12, 4'b0000);
        for (int i = 0; i < 3; i++) begin
            @(posedge i_sys_clk);
            supply[i] <= 1'b0;
            cyc(4);
            supply[i] <= 1'b1;
            cyc(4);
            #1 cmp_flags({o_por, 3'b000}, 4'b1000);
            cyc(10);
            #1 cmp_flags({o_por, 3'b000}, 4'b0000);
            settle();
        end
        wr(rgp_pkg::RGP_A_TIMER, 32'h1);
        wr(rgp_pkg::RGP_A_PIN, 32'h10);
        watch(5000, 4'b0000);
        src.pin(3, 1'b0);
        wr(rgp_pkg::RGP_A_PIN, 32'h13);
        src.pin(3, 1'b1);
        watch(3000, 4'b0000);
        src.pin(3, 1'b0);
        cyc(3);
        src.pin(3, 1'b1);
        watch(3000, 4'b0000);
        #1 cmp_flags({o_rc_force_on, o_rc_default_trim, 2'b00}, 4'b1000);
        watch(1200, 4'b1111);
        settle();
        wr(rgp_pkg::RGP_A_TIMER, 32'h1);
        wr(rgp_pkg::RGP_A_PIN, 32'h03);
        src.pin(3, 1'b0);
        watch(4200, 4'b1111);
        settle();
        print_verdict();
    end
endmodule // testbench
